// *** shared/gxc_regs.svh ***
`ifndef GXC_REGS_SVH
`define GXC_REGS_SVH
// Command codes, one byte each; two-byte values sit at an even code.
`define GXC_A_CTL_LO 7'h00
`define GXC_A_CTL_HI 7'h01
`define GXC_A_CYC    7'h2a
`define GXC_A_SOC    7'h2c
`define GXC_A_SOH    7'h2e
`define GXC_A_PCHG   7'h34
`define GXC_A_DEPTH_AT_LAST_OCV   7'h36
`define GXC_A_SDSC   7'h38
`define GXC_A_PACK   7'h3a
`define GXC_A_DCAP   7'h3c
`define GXC_A_CLS    7'h3e
`define GXC_A_BLK    7'h3f
`define GXC_A_BUF_LO 7'h40
`define GXC_A_BUF_LW 7'h54
`define GXC_A_BUF_HI 7'h5f
`define GXC_A_CKS    7'h60
`define GXC_A_BCTL   7'h61
`define GXC_A_NLEN   7'h62
`define GXC_A_NM_LO  7'h63
`define GXC_A_NM_HI  7'h6c
// Block select codes while locked, and the general-access control code.
`define GXC_BLK_AUTH 8'h00
`define GXC_BLK_A    8'h01
`define GXC_BLK_B    8'h02
`define GXC_BCTL_GEN 8'h00
// Arithmetic constants.
`define GXC_PCT_FULL 16'h0064
`define GXC_CKS_BASE 8'hff
`define GXC_CNT_MAX  16'hffff
`define GXC_BUF_LEN  6'h20
`define GXC_DIV_LEN  5'h17
// Reset values.
`define GXC_LOCK_RST 1'b1
`define GXC_BYTE_RST 8'h00
`endif

// *** shared/gxc_pkg.sv ***
package gxc_pkg;
	// Checksum and programming engine.
	typedef enum logic [1:0] {
		GXC_IDLE = 2'b00,
		GXC_SUM  = 2'b01,
		GXC_PROG = 2'b10
	} gxc_eng_t;
	// What the transfer buffer currently stands for.
	typedef enum logic [1:0] {
		GXC_RG_FLASH = 2'b00,
		GXC_RG_AUTH  = 2'b01,
		GXC_RG_A     = 2'b10,
		GXC_RG_B     = 2'b11
	} gxc_rgn_t;
endpackage : gxc_pkg

// *** shared/gxc_buf_if.sv ***
`timescale 1ns/1ps
// Port bundle between the command logic and the buffer memory.
interface gxc_buf_if #(parameter int W = 8, parameter int AW = 5);
	logic          we;    // Write strobe.
	logic [AW-1:0] waddr; // Write byte index.
	logic [W-1:0]  wdata; // Write byte.
	logic [AW-1:0] raddr; // Read byte index.
	logic [W-1:0]  rdata; // Registered read byte.
	modport ctl (output we, waddr, wdata, raddr, input rdata);
	modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface : gxc_buf_if

// *** design/gxc_buf_mem.sv ***
`timescale 1ns/1ps
// Transfer buffer storage; read data comes out of a register one cycle later.
module gxc_buf_mem #(
	parameter int DEPTH = 32
) (
	// Clock.
	input wire logic core_clk_i,
	// Access port.
	gxc_buf_if.mem   bus
);
	logic [7:0] mem_q [DEPTH]; // Byte array, no reset so it maps onto RAM.

	// Write port.
	always_ff @(posedge core_clk_i) begin
		if (bus.we) begin
			mem_q[bus.waddr] <= bus.wdata;
		end
	end

	// Registered read port.
	always_ff @(posedge core_clk_i) begin
		bus.rdata <= mem_q[bus.raddr];
	end
endmodule : gxc_buf_mem

// *** design/gxc_ext_cmd.sv ***
`timescale 1ns/1ps
`include "gxc_regs.svh"
// Behaviour
// RULE_01: Count cycles when discharge reaches threshold.
// RULE_02: Charge percent is remaining over full.
// RULE_03: Smoothing enable picks filtered capacity inputs.
// RULE_04: Health percent, 0 to 0x64, byte 0x2e.
// RULE_05: Report signed charge since last simulation.
// RULE_06: Report depth at last open-circuit reading.
// RULE_07: Report signed self-discharge estimate read-only.
// RULE_08: Extended commands accessed bytewise, variable length.
// RULE_09: Pack settings and nominal capacity always readable.
// RULE_10: Byte 0x3e selects the subclass.
// RULE_11: Locked: no flash access via 0x3e/0x3f.
// RULE_12: Unlocked general: block select picks 32-byte block.
// RULE_13: Locked block select: auth, block A, B.
// RULE_14: Buffer 0x40-0x5f; block A locked read-only.
// RULE_15: Locked: 0x55-0x5f read-only; reserved read-only.
// RULE_16: Checksum write requests programming of buffer.
// RULE_17: Host checksum is 255 minus byte sum.
// RULE_18: Access control 0x00 selects general data; unlocked.
// RULE_19: Name length readable in both states.
// RULE_20: Lock state changed by control subcommands.
// RULE_21: Program only after checksum verified correct.
// RULE_22: Block select carries offset over 32.
// RULE_23: Buffer data beyond 32 bytes is ignored; here it is dropped and the block is then refused at checksum.
// RULE_24: Locked writes to unavailable commands change nothing.
module gxc_ext_cmd
	import gxc_pkg::*;
#(
	parameter logic [15:0] SEAL_SUBCMD = 16'h0020 // Control word that locks the device.
) (
	// Clock and reset.
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	// Command port, one byte per access.
	input  wire logic        cmd_wr_i,
	input  wire logic        cmd_rd_i,
	input  wire logic        cmd_start_i,
	input  wire logic [6:0]  cmd_addr_i,
	input  wire logic [7:0]  cmd_wdata_i,
	output logic             cmd_ready_o,
	output logic [7:0]       cmd_rdata_o,
	output logic             cmd_rvalid_o,
	// Gauge results.
	input  wire logic        dsg_valid_i,
	input  wire logic [15:0] dsg_mah_i,
	input  wire logic [15:0] cycle_discharge_threshold_i,
	input  wire logic        smoothing_enable_i,
	input  wire logic [15:0] remaining_filt_i,
	input  wire logic [15:0] remaining_unfilt_i,
	input  wire logic [15:0] full_filt_i,
	input  wire logic [15:0] full_unfilt_i,
	input  wire logic [15:0] health_full_i,
	input  wire logic [15:0] charge_since_simulation_i,
	input  wire logic [15:0] depth_at_last_ocv_i,
	input  wire logic [15:0] self_discharge_estimate_i,
	// Stored configuration.
	input  wire logic [15:0] pack_settings_mirror_i,
	input  wire logic [15:0] nominal_pack_capacity_i,
	input  wire logic [7:0]  name_length_i,
	input  wire logic [79:0] name_text_i,
	// Lock state.
	input  wire logic        unlock_grant_i,
	output logic             unlocked_state_o,
	// Non-volatile store side.
	output logic             nv_load_o,
	output logic [7:0]       nv_class_o,
	output logic [7:0]       nv_block_o,
	output gxc_pkg::gxc_rgn_t nv_region_o,
	input  wire logic        nv_fill_valid_i,
	input  wire logic [4:0]  nv_fill_idx_i,
	input  wire logic [7:0]  nv_fill_data_i,
	output logic             nv_prog_valid_o,
	output logic [4:0]       nv_prog_idx_o,
	output logic [7:0]       nv_prog_data_o,
	output logic             nv_commit_o,
	output logic             cks_error_o,
	output logic             auth_route_o
);
	gxc_buf_if #(.W(8), .AW(5)) bif ();

	gxc_buf_mem #(.DEPTH(32)) u_mem (
		.core_clk_i (core_clk_i),
		.bus        (bif)
	);

	logic        locked_q;     // One while locked.
	logic [7:0]  cls_q;        // Subclass select.
	logic [7:0]  blk_q;        // Block select.
	logic [7:0]  bctl_q;       // Access control byte.
	logic [7:0]  cks_q;        // Last checksum written.
	logic [7:0]  ctl_lo_q;     // Low byte of the control word.
	gxc_rgn_t    rgn_q;        // Buffer meaning.
	logic [15:0] cyc_q;        // Cycle total.
	logic [15:0] acc_q;        // Discharge accumulated toward one cycle.
	logic [15:0] soc_q;        // Charge percent.
	logic [15:0] soh_q;        // Health percent.
	logic [5:0]  tx_cnt_q;     // Buffer bytes in this transaction.
	logic        ovf_q;        // Buffer overrun seen since block select.
	gxc_eng_t    eng_q;        // Engine state.
	logic [5:0]  eng_idx_q;    // Engine byte index.
	logic [7:0]  sum_q;        // Running byte sum.
	logic        cks_ok_q;     // Last checksum matched.
	logic [7:0]  rd_q;         // Register read data.
	logic        rbuf_q;       // Last read came from the buffer.

	// Access decode.
	logic acc_wr, acc_rd, in_buf, buf_wr_ok, cks_wr, prog_ok;
	logic [4:0] buf_idx;
	assign acc_wr  = cmd_wr_i & cmd_ready_o;
	assign acc_rd  = cmd_rd_i & cmd_ready_o;
	assign in_buf  = (cmd_addr_i >= `GXC_A_BUF_LO) && (cmd_addr_i <= `GXC_A_BUF_HI);
	assign buf_idx = 5'(cmd_addr_i - `GXC_A_BUF_LO); // RULE_22
	// Locked: only low bytes, never block A; overrun bytes dropped.
	assign buf_wr_ok = in_buf && (!locked_q ||
		((cmd_addr_i <= `GXC_A_BUF_LW) && (rgn_q != GXC_RG_A))) // RULE_14 RULE_15
		&& (cmd_start_i || (tx_cnt_q < `GXC_BUF_LEN)); // RULE_23
	assign cks_wr  = acc_wr && (cmd_addr_i == `GXC_A_CKS);
	// Programming is open when unlocked, and for block B only when locked; never after a buffer overrun.
	assign prog_ok = !ovf_q && (!locked_q || (rgn_q == GXC_RG_B)); // RULE_24

	// The store loading the buffer takes priority; the host waits meanwhile.
	assign cmd_ready_o = (eng_q == GXC_IDLE) && !nv_fill_valid_i;

	// Buffer port steering; the engine owns the read side while it runs.
	always_comb begin
		bif.we    = nv_fill_valid_i | (acc_wr & buf_wr_ok);
		bif.waddr = nv_fill_valid_i ? nv_fill_idx_i : buf_idx;
		bif.wdata = nv_fill_valid_i ? nv_fill_data_i : cmd_wdata_i;
		bif.raddr = (eng_q == GXC_IDLE) ? buf_idx : eng_idx_q[4:0];
	end

	// Lock state: the control word written low then high locks it; unlock_grant_i clears it.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			locked_q <= `GXC_LOCK_RST;
			ctl_lo_q <= `GXC_BYTE_RST;
		end else begin
			if (acc_wr && (cmd_addr_i == `GXC_A_CTL_LO)) begin
				ctl_lo_q <= cmd_wdata_i;
			end
			if (acc_wr && (cmd_addr_i == `GXC_A_CTL_HI)
				&& ({cmd_wdata_i, ctl_lo_q} == SEAL_SUBCMD)) begin
				locked_q <= 1'b1; // RULE_20
			end else if (unlock_grant_i) begin
				locked_q <= 1'b0; // RULE_20
			end
		end
	end

	// Selection bytes; locked writes to unavailable ones are dropped.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cls_q  <= `GXC_BYTE_RST;
			bctl_q <= `GXC_BYTE_RST;
			blk_q  <= `GXC_BYTE_RST;
		end else if (acc_wr && !locked_q) begin
			if (cmd_addr_i == `GXC_A_CLS) begin
				cls_q <= cmd_wdata_i; // RULE_10 RULE_11
			end
			if (cmd_addr_i == `GXC_A_BCTL) begin
				bctl_q <= cmd_wdata_i; // RULE_18
			end
			if (cmd_addr_i == `GXC_A_BLK) begin
				blk_q <= cmd_wdata_i; // RULE_12
			end
		end else if (acc_wr && (cmd_addr_i == `GXC_A_BLK)
			&& (cmd_wdata_i <= `GXC_BLK_B)) begin
			blk_q <= cmd_wdata_i; // RULE_13
		end
	end

	// Buffer meaning; a locked block write of 0, 1 or 2 retargets it.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			rgn_q <= GXC_RG_AUTH;
		end else if (acc_wr && (cmd_addr_i == `GXC_A_BLK)) begin
			if (!locked_q) begin
				rgn_q <= GXC_RG_FLASH; // RULE_12
			end else if (cmd_wdata_i == `GXC_BLK_AUTH) begin
				rgn_q <= GXC_RG_AUTH; // RULE_13
			end else if (cmd_wdata_i == `GXC_BLK_A) begin
				rgn_q <= GXC_RG_A; // RULE_13
			end else if (cmd_wdata_i == `GXC_BLK_B) begin
				rgn_q <= GXC_RG_B; // RULE_13
			end
		end else if (acc_wr && (cmd_addr_i == `GXC_A_CTL_HI) && locked_q) begin
			rgn_q <= rgn_q;
		end
	end

	// Block loads: auth data is not fetched; blocks A and B are, and flash blocks only under general access control.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			nv_load_o <= 1'b0;
		end else begin
			nv_load_o <= acc_wr && (cmd_addr_i == `GXC_A_BLK)
				&& ((!locked_q && (bctl_q == `GXC_BCTL_GEN)) // RULE_12 RULE_18
				|| (locked_q && ((cmd_wdata_i == `GXC_BLK_A)
				|| (cmd_wdata_i == `GXC_BLK_B)))); // RULE_13
		end
	end
	assign nv_class_o   = cls_q;
	assign nv_block_o   = blk_q; // RULE_22
	assign nv_region_o  = rgn_q;
	assign auth_route_o = locked_q && (rgn_q == GXC_RG_AUTH); // RULE_13
	assign unlocked_state_o = !locked_q;

	// Overrun tracking: a transaction may put at most 32 bytes in the buffer.
	// Overrun data cannot be taken back, so the block is refused at checksum.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			tx_cnt_q <= 6'h00;
			ovf_q    <= 1'b0;
		end else if (acc_wr && (cmd_addr_i == `GXC_A_BLK)) begin
			tx_cnt_q <= 6'h00;
			ovf_q    <= 1'b0;
		end else if (acc_wr && in_buf) begin
			if (cmd_start_i) begin
				tx_cnt_q <= 6'h01;
			end else if (tx_cnt_q < `GXC_BUF_LEN) begin
				tx_cnt_q <= tx_cnt_q + 6'h01;
			end else begin
				ovf_q <= 1'b1; // RULE_23
			end
		end else if (acc_wr && cmd_start_i) begin
			tx_cnt_q <= 6'h00;
		end
	end

	// Checksum capture.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cks_q <= `GXC_BYTE_RST;
		end else if (cks_wr && !(locked_q && (rgn_q == GXC_RG_A))) begin
			cks_q <= cmd_wdata_i; // RULE_16
		end
	end

	// Engine: sum the 32 bytes, compare, then stream them to the store.
	// The sum is one byte late because the buffer read is registered.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			eng_q     <= GXC_IDLE;
			eng_idx_q <= 6'h00;
			sum_q     <= 8'h00;
			cks_ok_q  <= 1'b0;
		end else begin
			case (eng_q)
				GXC_IDLE: begin
					eng_idx_q <= 6'h00;
					sum_q     <= 8'h00;
					if (cks_wr && prog_ok) begin
						eng_q <= GXC_SUM; // RULE_16
					end
				end
				GXC_SUM: begin
					eng_idx_q <= eng_idx_q + 6'h01;
					if (eng_idx_q != 6'h00) begin
						sum_q <= sum_q + bif.rdata;
					end
					if (eng_idx_q == `GXC_BUF_LEN) begin
						cks_ok_q  <= (`GXC_CKS_BASE - (sum_q + bif.rdata)) == cks_q; // RULE_17
						eng_idx_q <= 6'h00;
						eng_q     <= ((`GXC_CKS_BASE - (sum_q + bif.rdata)) == cks_q)
							? GXC_PROG : GXC_IDLE; // RULE_21
					end
				end
				GXC_PROG: begin
					eng_idx_q <= eng_idx_q + 6'h01;
					if (eng_idx_q == `GXC_BUF_LEN) begin
						eng_q <= GXC_IDLE;
					end
				end
				default: begin
					eng_q <= GXC_IDLE;
				end
			endcase
		end
	end

	// Store stream and completion flags.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			nv_prog_valid_o <= 1'b0;
			nv_prog_idx_o   <= 5'h00;
			nv_commit_o     <= 1'b0;
			cks_error_o     <= 1'b0;
		end else begin
			nv_prog_valid_o <= (eng_q == GXC_PROG) && (eng_idx_q != `GXC_BUF_LEN);
			nv_prog_idx_o   <= eng_idx_q[4:0];
			nv_commit_o     <= (eng_q == GXC_PROG) && (eng_idx_q == `GXC_BUF_LEN); // RULE_21
			if (cks_wr) begin
				cks_error_o <= !prog_ok;
			end else if ((eng_q == GXC_SUM) && (eng_idx_q == `GXC_BUF_LEN)) begin
				cks_error_o <= (`GXC_CKS_BASE - (sum_q + bif.rdata)) != cks_q;
			end
		end
	end
	assign nv_prog_data_o = bif.rdata;

	// Cycle total: carry the excess over the threshold, saturate at the top.
	logic [16:0] acc_sum;
	assign acc_sum = {1'b0, acc_q} + {1'b0, dsg_mah_i};
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cyc_q <= 16'h0000;
			acc_q <= 16'h0000;
		end else if (dsg_valid_i) begin
			if ((cycle_discharge_threshold_i != 16'h0000)
				&& (acc_sum >= {1'b0, cycle_discharge_threshold_i})) begin
				acc_q <= 16'(acc_sum - {1'b0, cycle_discharge_threshold_i});
				if (cyc_q != `GXC_CNT_MAX) begin
					cyc_q <= cyc_q + 16'h0001; // RULE_01
				end
			end else begin
				acc_q <= acc_sum[15:0];
			end
		end
	end

	// Shared divider: alternates between charge and health percent jobs.
	// A serial divider costs 24 cycles per update, far below gauge rates.
	logic        job_q;
	logic [4:0]  div_cnt_q;
	logic [22:0] div_quo_q;
	logic [16:0] div_rem_q;
	logic [15:0] div_den_q;
	logic [16:0] rem_sh;
	logic [15:0] pct_num, pct_den, quo_cap;
	assign pct_num = job_q ? health_full_i
		: (smoothing_enable_i ? remaining_filt_i : remaining_unfilt_i); // RULE_03
	assign pct_den = job_q ? nominal_pack_capacity_i
		: (smoothing_enable_i ? full_filt_i : full_unfilt_i); // RULE_03
	assign rem_sh  = {div_rem_q[15:0], div_quo_q[22]};
	assign quo_cap = (div_quo_q > 23'(`GXC_PCT_FULL)) ? `GXC_PCT_FULL : div_quo_q[15:0];
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			job_q     <= 1'b0;
			div_cnt_q <= 5'h00;
			div_quo_q <= 23'h000000;
			div_rem_q <= 17'h00000;
			div_den_q <= 16'h0000;
		end else if (div_cnt_q == 5'h00) begin
			// Widen before the product so a large capacity cannot wrap at 16 bits.
			div_quo_q <= 23'(pct_num) * 23'(`GXC_PCT_FULL);
			div_den_q <= pct_den;
			div_rem_q <= 17'h00000;
			div_cnt_q <= `GXC_DIV_LEN;
		end else begin
			div_cnt_q <= div_cnt_q - 5'h01;
			if (rem_sh >= {1'b0, div_den_q}) begin
				div_rem_q <= rem_sh - {1'b0, div_den_q};
				div_quo_q <= {div_quo_q[21:0], 1'b1};
			end else begin
				div_rem_q <= rem_sh;
				div_quo_q <= {div_quo_q[21:0], 1'b0};
			end
			if (div_cnt_q == 5'h01) begin
				job_q <= !job_q;
			end
		end
	end

	// Result capture when a division has finished.
	// The job flag has already flipped, so it names the job that comes next.
	// A zero denominator runs to the end, but its result is never captured.
	logic div_done;
	assign div_done = (div_cnt_q == 5'h00) && (div_den_q != 16'h0000);
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			soc_q <= 16'h0000;
		end else if (div_done && job_q) begin
			soc_q <= quo_cap; // RULE_02
		end
	end

	// Health result is limited to 0x64.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			soh_q <= 16'h0000;
		end else if (div_done && !job_q) begin
			soh_q <= quo_cap; // RULE_04
		end
	end

	// Read mux; odd codes return the high byte of a two-byte value.
	function automatic logic [7:0] pick(input logic [15:0] w, input logic hi);
		pick = hi ? w[15:8] : w[7:0];
	endfunction : pick
	logic [6:0] wbase;
	logic [3:0] nm_idx;
	assign wbase  = {cmd_addr_i[6:1], 1'b0};
	assign nm_idx = 4'(cmd_addr_i - `GXC_A_NM_LO);
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			rd_q         <= `GXC_BYTE_RST;
			rbuf_q       <= 1'b0;
			cmd_rvalid_o <= 1'b0;
		end else begin
			cmd_rvalid_o <= acc_rd;
			rbuf_q       <= in_buf; // RULE_14
			if (acc_rd) begin
				rd_q <= `GXC_BYTE_RST; // Reserved codes read zero. RULE_15
				if (cmd_addr_i == `GXC_A_CLS) begin
					rd_q <= locked_q ? `GXC_BYTE_RST : cls_q;
				end else if (cmd_addr_i == `GXC_A_BLK) begin
					rd_q <= blk_q;
				end else if (cmd_addr_i == `GXC_A_CKS) begin
					rd_q <= cks_q;
				end else if (cmd_addr_i == `GXC_A_BCTL) begin
					rd_q <= locked_q ? `GXC_BYTE_RST : bctl_q; // RULE_18
				end else if (cmd_addr_i == `GXC_A_NLEN) begin
					rd_q <= name_length_i; // RULE_19
				end else if ((cmd_addr_i >= `GXC_A_NM_LO) && (cmd_addr_i <= `GXC_A_NM_HI)) begin
					rd_q <= name_text_i[nm_idx*8 +: 8];
				end else begin
					case (wbase) // RULE_08
						`GXC_A_CYC:  rd_q <= pick(cyc_q, cmd_addr_i[0]); // RULE_01
						`GXC_A_SOC:  rd_q <= pick(soc_q, cmd_addr_i[0]); // RULE_02
						`GXC_A_SOH:  rd_q <= pick(soh_q, cmd_addr_i[0]); // RULE_04
						`GXC_A_PCHG: rd_q <= pick(charge_since_simulation_i, cmd_addr_i[0]); // RULE_05
						`GXC_A_DEPTH_AT_LAST_OCV: rd_q <= pick(depth_at_last_ocv_i, cmd_addr_i[0]); // RULE_06
						`GXC_A_SDSC: rd_q <= pick(self_discharge_estimate_i, cmd_addr_i[0]); // RULE_07
						`GXC_A_PACK: rd_q <= pick(pack_settings_mirror_i, cmd_addr_i[0]); // RULE_09
						`GXC_A_DCAP: rd_q <= pick(nominal_pack_capacity_i, cmd_addr_i[0]); // RULE_09
						default:     rd_q <= `GXC_BYTE_RST;
					endcase
				end
			end
		end
	end
	assign cmd_rdata_o = rbuf_q ? bif.rdata : rd_q;

	// Checks.
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	sequence s_cks_go;
		cks_wr && prog_ok && (eng_q == GXC_IDLE);
	endsequence
	sequence s_sum_run;
		(eng_q == GXC_SUM) [*8];
	endsequence
	a_prog_start_sum: assert property (s_cks_go |=> s_sum_run) // RULE_16
		else $error("checksum write did not start summing");
	a_commit_after_ok: assert property (nv_commit_o |-> cks_ok_q) // RULE_21
		else $error("commit without a verified checksum");
	a_locked_cls_hold: assert property (locked_q && acc_wr
		&& (cmd_addr_i == `GXC_A_CLS) |=> $stable(cls_q)) // RULE_11
		else $error("class select changed while locked");
	a_locked_buf_ro: assert property (locked_q && acc_wr && !nv_fill_valid_i
		&& (cmd_addr_i > `GXC_A_BUF_LW) |-> !bif.we) // RULE_15
		else $error("locked write reached read-only buffer byte");
	a_locked_ctl_hold: assert property (locked_q && acc_wr
		&& (cmd_addr_i == `GXC_A_BCTL) |=> $stable(bctl_q)) // RULE_24
		else $error("access control changed while locked");
	a_cycle_step: assert property (dsg_valid_i && (cycle_discharge_threshold_i != 16'h0000)
		&& (acc_sum >= {1'b0, cycle_discharge_threshold_i}) && (cyc_q != `GXC_CNT_MAX)
		|=> cyc_q == $past(cyc_q) + 16'h0001) // RULE_01
		else $error("cycle total missed a step");
	a_soc_range: assert property (soc_q <= `GXC_PCT_FULL) // RULE_02
		else $error("charge percent above 100");
	a_soh_range: assert property (soh_q <= `GXC_PCT_FULL) // RULE_04
		else $error("health percent above 0x64");
	a_read_answer: assert property (acc_rd |=> cmd_rvalid_o) // RULE_08
		else $error("read answer missing");
endmodule : gxc_ext_cmd

// *** sim/gxc_nv_model.sv ***
`timescale 1ns/1ps
// Store stand-in: refills the buffer after a fetch and records programmed bytes.
module gxc_nv_model (
	// Clock.
	input  wire logic       core_clk_i,
	// Fetch and programming stream from the block.
	input  wire logic       nv_load_i,
	input  wire logic       nv_prog_valid_i,
	input  wire logic [4:0] nv_prog_idx_i,
	input  wire logic [7:0] nv_prog_data_i,
	input  wire logic       nv_commit_i,
	// Fill stream into the buffer.
	output logic            fill_valid_o,
	output logic [4:0]      fill_idx_o,
	output logic [7:0]      fill_data_o
);
	logic [7:0] prog_q [32]; // Last programmed image.
	int         commits = 0; // Finished programming runs.
	initial begin
		fill_valid_o = 1'b0;
		fill_idx_o = 5'h00;
		fill_data_o = 8'h00;
	end
	// A fetch is answered slowly; idle data toggles so a stale byte is never mistaken for fill.
	always @(posedge core_clk_i) begin
		if (nv_load_i) begin
			repeat (2) @(posedge core_clk_i);
			for (int i = 0; i < 32; i++) begin
				fill_valid_o <= 1'b1;
				fill_idx_o <= 5'(i);
				fill_data_o <= 8'(i) ^ 8'h5a;
				@(posedge core_clk_i);
			end
			fill_valid_o <= 1'b0;
		end else begin
			fill_data_o <= ~fill_data_o;
		end
	end
	// Capture of the programming stream.
	always @(posedge core_clk_i) begin
		if (nv_prog_valid_i) begin
			prog_q[nv_prog_idx_i] <= nv_prog_data_i;
		end
		if (nv_commit_i) begin
			commits <= commits + 1;
		end
	end
endmodule : gxc_nv_model

// *** sim/tb.sv ***
`timescale 1ns/1ps
// Self-checking bench: host byte accesses against the extended command block.
module tb;
	import gxc_pkg::*;
	logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, st = 1'b0;
	logic [6:0]  addr = 7'h00;
	logic [7:0]  wd = 8'h00, rdat, sum, nl = 8'h0a;
	logic        rdy, rv, dv = 1'b0, sm = 1'b1, grant = 1'b0;
	logic        unl, ld, pv, cm, cerr, auth, fv;
	logic [7:0]  cls, blk, pd, fd;
	logic [4:0]  pi, fi;
	logic [15:0] dmah = 16'h000a;
	logic [79:0] nm = 80'h00112233445566778899;
	// Gauge inputs: threshold, rem f/u, full f/u, health, charge, depth, self, pack, capacity.
	logic [15:0] g [11] = '{16'h000a, 16'h0032, 16'h001e, 16'h0064, 16'h0078, 16'h0050,
		16'hfff0, 16'h1234, 16'h8001, 16'h0a5c, 16'h00c8};
	gxc_rgn_t    rgn;
	int          n_mismatch = 0, check_count = 0, cyc = 0;
	always #2.5 clk = ~clk;
	gxc_ext_cmd uut (.core_clk_i(clk), .srst_i(srst), .cmd_wr_i(wr), .cmd_rd_i(rd),
		.cmd_start_i(st), .cmd_addr_i(addr), .cmd_wdata_i(wd), .cmd_ready_o(rdy),
		.cmd_rdata_o(rdat), .cmd_rvalid_o(rv), .dsg_valid_i(dv), .dsg_mah_i(dmah),
		.cycle_discharge_threshold_i(g[0]), .smoothing_enable_i(sm),
		.remaining_filt_i(g[1]), .remaining_unfilt_i(g[2]), .full_filt_i(g[3]),
		.full_unfilt_i(g[4]), .health_full_i(g[5]), .charge_since_simulation_i(g[6]),
		.depth_at_last_ocv_i(g[7]), .self_discharge_estimate_i(g[8]),
		.pack_settings_mirror_i(g[9]), .nominal_pack_capacity_i(g[10]),
		.name_length_i(nl), .name_text_i(nm), .unlock_grant_i(grant),
		.unlocked_state_o(unl), .nv_load_o(ld), .nv_class_o(cls), .nv_block_o(blk),
		.nv_region_o(rgn), .nv_fill_valid_i(fv), .nv_fill_idx_i(fi), .nv_fill_data_i(fd),
		.nv_prog_valid_o(pv), .nv_prog_idx_o(pi), .nv_prog_data_o(pd), .nv_commit_o(cm),
		.cks_error_o(cerr), .auth_route_o(auth));
	gxc_nv_model nv (.core_clk_i(clk), .nv_load_i(ld), .nv_prog_valid_i(pv),
		.nv_prog_idx_i(pi), .nv_prog_data_i(pd), .nv_commit_i(cm), .fill_valid_o(fv),
		.fill_idx_o(fi), .fill_data_o(fd));
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test
	// One comparison; case inequality so an unknown never matches.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One byte access, held until an edge that sees ready high.
	task automatic xfer(input logic w, input logic s, input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		st <= s;
		addr <= a;
		wd <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		wr <= 1'b0;
		rd <= 1'b0;
		st <= 1'b0;
		#1;
	endtask : xfer
	// Read one byte; a missing valid strobe turns into a mismatch.
	task automatic rdc(input logic [6:0] a, input logic [7:0] e);
		xfer(1'b0, 1'b1, a, 8'h00);
		chk((rv === 1'b1) ? rdat : ~e, e);
	endtask : rdc
	// Sixteen-bit values are two byte reads, low byte at the even code.
	task automatic rd16(input logic [6:0] a, input logic [15:0] e);
		rdc(a, e[7:0]);
		rdc(a + 7'h01, e[15:8]);
	endtask : rd16
	// Hang guard: the sequence needs a few thousand cycles at most.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk({7'h00, unl}, 8'h00);
		rd16(7'h34, g[6]);
		rd16(7'h36, g[7]);
		rd16(7'h38, g[8]);
		rd16(7'h3a, g[9]);
		rd16(7'h3c, g[10]);
		rdc(7'h62, nl);
		rdc(7'h63, nm[7:0]);
		// Two discharges reach the threshold exactly, the third stays below it.
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			dv <= 1'b1;
			dmah <= (i == 2) ? 16'h0005 : 16'h000a;
			@(posedge clk);
			dv <= 1'b0;
		end
		rd16(7'h2a, 16'h0002);
		repeat (60) @(posedge clk);
		rd16(7'h2c, 16'h0032);
		rdc(7'h2e, 8'h28);
		sm <= 1'b0;
		repeat (100) @(posedge clk);
		rd16(7'h2c, 16'h0019);
		g[2] <= 16'h00c8;
		repeat (100) @(posedge clk);
		rd16(7'h2c, 16'h0064);
		// Locked: class writes are dropped, info A is read-only.
		xfer(1'b1, 1'b1, 7'h3e, 8'h55);
		xfer(1'b1, 1'b1, 7'h3f, 8'h01);
		repeat (40) @(posedge clk);
		chk({6'h00, rgn}, {6'h00, GXC_RG_A});
		xfer(1'b1, 1'b1, 7'h45, 8'h00);
		rdc(7'h45, 8'h5f);
		xfer(1'b1, 1'b1, 7'h3f, 8'h02);
		repeat (40) @(posedge clk);
		xfer(1'b1, 1'b1, 7'h54, 8'h77);
		xfer(1'b1, 1'b0, 7'h55, 8'h11);
		rdc(7'h54, 8'h77);
		rdc(7'h55, 8'h4f);
		xfer(1'b1, 1'b1, 7'h3f, 8'h00);
		repeat (40) @(posedge clk);
		chk({7'h00, auth}, 8'h01);
		// Unlock, then select general data, class and second block.
		@(posedge clk);
		grant <= 1'b1;
		@(posedge clk);
		grant <= 1'b0;
		rdc(7'h3e, 8'h00);
		chk({7'h00, unl}, 8'h01);
		xfer(1'b1, 1'b1, 7'h61, 8'h00);
		xfer(1'b1, 1'b1, 7'h3e, 8'h3a);
		xfer(1'b1, 1'b1, 7'h3f, 8'h01);
		repeat (40) @(posedge clk);
		chk(cls, 8'h3a);
		chk(blk, 8'h01);
		chk({6'h00, rgn}, {6'h00, GXC_RG_FLASH});
		rdc(7'h41, 8'h5b);
		// Full block with a good checksum, then the same block with a wrong one.
		sum = 8'h00;
		for (int i = 0; i < 32; i++) begin
			xfer(1'b1, i == 0, 7'h40 + 7'(i), 8'h10 + 8'(i));
			sum = sum + 8'h10 + 8'(i);
		end
		xfer(1'b1, 1'b1, 7'h60, 8'hff - sum);
		repeat (150) @(posedge clk);
		chk(8'(nv.commits), 8'h01);
		chk(nv.prog_q[0], 8'h10);
		chk(nv.prog_q[31], 8'h2f);
		xfer(1'b1, 1'b1, 7'h60, (8'hff - sum) ^ 8'h01);
		repeat (150) @(posedge clk);
		chk({7'h00, cerr}, 8'h01);
		// A 33-byte transaction overruns; even a correct checksum is then refused.
		for (int i = 0; i < 33; i++) begin
			xfer(1'b1, i == 0, 7'h40 + 7'(i % 32), 8'h01);
		end
		xfer(1'b1, 1'b1, 7'h60, 8'hdf);
		repeat (150) @(posedge clk);
		chk(8'(nv.commits), 8'h01);
		chk({7'h00, cerr}, 8'h01);
		// Lock subcommand, low byte then high byte.
		xfer(1'b1, 1'b1, 7'h00, 8'h20);
		xfer(1'b1, 1'b0, 7'h01, 8'h00);
		@(posedge clk);
		chk({7'h00, unl}, 8'h00);
		// Locked: info B programs with a good checksum, info A refuses it.
		xfer(1'b1, 1'b1, 7'h3f, 8'h02);
		repeat (40) @(posedge clk);
		xfer(1'b1, 1'b1, 7'h60, 8'h0f);
		repeat (150) @(posedge clk);
		chk(8'(nv.commits), 8'h02);
		chk(nv.prog_q[5], 8'h5f);
		chk({7'h00, cerr}, 8'h00);
		xfer(1'b1, 1'b1, 7'h3f, 8'h01);
		repeat (40) @(posedge clk);
		xfer(1'b1, 1'b1, 7'h60, 8'h0f);
		@(posedge clk);
		chk({7'h00, cerr}, 8'h01);
		repeat (150) @(posedge clk);
		chk(8'(nv.commits), 8'h02);
		stop_test();
	end
endmodule : tb
